// ===== hw/reconnect_regs.vh
// Register map, field positions and constants of the reconnection permit block
`ifndef RECONNECT_REGS_VH
`define RECONNECT_REGS_VH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define REG_CTRL0 8'h00
`define REG_CTRL1 8'h04
`define REG_VLIM0 8'h08
`define REG_FLIM0 8'h0C
`define REG_VLIM1 8'h10
`define REG_FLIM1 8'h14
`define REG_DELAY0 8'h18
`define REG_DELAY1 8'h1C
`define REG_STAT 8'h20
`define REG_IRQ_STAT 8'h24
`define REG_IRQ_MASK 8'h28

// ---------------------------------------------------------------------------
// Control register fields (per instance)
// ---------------------------------------------------------------------------
`define CTRL_EN 0
`define CTRL_VTSUP 1
`define CTRL_BRK_ASSIGN 2
`define CTRL_USE_VLIM 3
`define CTRL_USE_FLIM 4
`define CTRL_USE_EXTOK 5
`define CTRL_CROSS_BLK 6
`define CTRL_DEC_LSB 8
`define CTRL_DEC_MSB 17
`define CTRL_RESET 32'h0000_0000

// Decoupling sources: 6 protection trips plus 4 misc (input, equation, remote)
`define DEC_W 10

// Limit registers: low half minimum, high half maximum
`define LIM_LO_MSB 15
`define LIM_HI_LSB 16
`define LIM_HI_MSB 31
`define MEAS_W 16
`define VLIM_RESET 32'hFFFF_0000
`define FLIM_RESET 32'hFFFF_0000

// Settle delay in evaluation ticks
`define DLY_W 32
`define DLY_RESET 32'h0000_0010

// Interrupt events: per instance release rise, eval rise (2 bits each)
`define IRQ_W 4
`define IRQ_ZERO 4'h0

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`define DATA_ZERO 32'h0000_0000

`endif

// ===== hw/reconnect_channel.v
// One reconnection permit instance: trigger, release check and settle timer
`timescale 1ns/1ps
`include "reconnect_regs.vh"
module reconnect_channel (
    input wire clk,
    input wire srst,
    input wire [31:0] ctrl,
    input wire [31:0] vLim,
    input wire [31:0] fLim,
    input wire [31:0] settleDelay,
    input wire [`DEC_W-1:0] decoupleIn,
    input wire breakerClosed,
    input wire [15:0] voltage,
    input wire [15:0] frequency,
    input wire external_voltage_ok_input,
    input wire vt_fuse_failure_input,
    input wire external_logic_block_input,
    input wire blockIn,
    output wire reclosePermit,
    output wire evalActive
);
    // -----------------------------------------------------------------------
    // States
    // -----------------------------------------------------------------------
    localparam IDLE = 2'd0;
    localparam ARMED = 2'd1; // Unused; a trigger moves IDLE straight to EVAL
    localparam EVAL = 2'd2;
    localparam RELEASED = 2'd3;

    reg [1:0] state_q; // Phase of the channel
    reg [1:0] state_d;
    reg [31:0] timer_q; // Settle count in ticks
    reg [31:0] timer_d;
    reg brk_q; // Last breaker position
    reg extOk_q; // Last external release level
    reg condOk_q; // Last value of the limit check (limOk)
    reg [`DEC_W-1:0] dec_q; // Last decoupling vector

    wire [`DEC_W-1:0] decMask = ctrl[`CTRL_DEC_MSB:`CTRL_DEC_LSB];
    wire useBrk = ctrl[`CTRL_BRK_ASSIGN];
    wire useDec = |decMask;
    wire decNow = |(decoupleIn & decMask);
    wire decRise = |(decoupleIn & decMask & ~dec_q);
    // Limits: inclusive window, only where enabled
    wire vIn = (voltage >= vLim[`LIM_LO_MSB:0]) && (voltage <= vLim[`LIM_HI_MSB:`LIM_HI_LSB]);
    wire fIn = (frequency >= fLim[`LIM_LO_MSB:0]) &&
        (frequency <= fLim[`LIM_HI_MSB:`LIM_HI_LSB]);
    wire limOk = (!ctrl[`CTRL_USE_VLIM] || vIn) && (!ctrl[`CTRL_USE_FLIM] || fIn);
    wire extOk = !ctrl[`CTRL_USE_EXTOK] || external_voltage_ok_input;
    wire condOk = limOk && extOk;
    // Out of limits or external release lost triggers evaluation
    wire condTrig = (!limOk && condOk_q) ||
        (ctrl[`CTRL_USE_EXTOK] && extOk_q && !external_voltage_ok_input);
    wire brkFall = brk_q && !breakerClosed;
    // Complete block: disabled, external block, fuse failure, other instance
    // Cross-instance block arrives through blockIn from the top
    wire blocked = !ctrl[`CTRL_EN] || blockIn ||
        (ctrl[`CTRL_VTSUP] && vt_fuse_failure_input);
    wire releaseOk = condOk && !(useDec && decNow) && !external_logic_block_input;
    wire trigger = (useBrk && useDec) ? (brkFall && decNow) :
        useBrk ? brkFall :
        useDec ? decRise :
        condTrig;

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------
    always @* begin
        state_d = state_q;
        timer_d = timer_q;
        case (state_q)
            IDLE: begin
                if (trigger) begin
                    state_d = EVAL;
                    timer_d = `DATA_ZERO;
                end
            end
            EVAL: begin
                if (!releaseOk || (useBrk && breakerClosed)) begin
                    timer_d = `DATA_ZERO;
                end else if (timer_q >= settleDelay) begin
                    state_d = RELEASED;
                end else begin
                    timer_d = timer_q + 32'h0000_0001;
                end
            end
            RELEASED: begin
                // Drop when reconnected, new decoupling or condition loss
                if ((useBrk && breakerClosed) || (useDec && decRise) ||
                    !condOk || external_logic_block_input) begin
                    state_d = IDLE;
                    // Without breaker feedback nothing else would restart the check
                    if (!useBrk) begin
                        state_d = EVAL;
                        timer_d = `DATA_ZERO;
                    end
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    // -----------------------------------------------------------------------
    // Registers; block forces idle
    // -----------------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            state_q <= IDLE;
            timer_q <= `DATA_ZERO;
            brk_q <= 1'b0;
            extOk_q <= 1'b0;
            condOk_q <= 1'b0;
            dec_q <= {`DEC_W{1'b0}};
        end else begin
            brk_q <= breakerClosed;
            extOk_q <= external_voltage_ok_input;
            condOk_q <= limOk;
            dec_q <= decoupleIn;
            if (blocked) begin
                state_q <= IDLE;
                timer_q <= `DATA_ZERO;
            end else begin
                state_q <= state_d;
                timer_q <= timer_d;
            end
        end
    end

    assign reclosePermit = (state_q == RELEASED);
    assign evalActive = (state_q == EVAL);
endmodule // reconnect_channel

// ===== hw/reconnect_permit.v
// Top of the mains reconnection permit block with AXI4-Lite registers
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "reconnect_regs.vh"
module reconnect_permit (
    input wire clk,
    input wire srst,
    // AXI4-Lite slave
    input wire [7:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Field side, shared measurements
    input wire [`DEC_W-1:0] decoupleIn,
    input wire breakerClosed,
    input wire [15:0] voltage,
    input wire [15:0] frequency,
    input wire external_voltage_ok_input,
    input wire vt_fuse_failure_input,
    input wire [1:0] external_logic_block_input,
    input wire [1:0] blockIn,
    output reg [1:0] reclosePermit,
    output reg [1:0] evalActive,
    output reg irq
);
    // -----------------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------------
    reg [31:0] ctrl_q [0:1]; // Per instance control
    reg [31:0] vLim_q [0:1]; // Voltage window
    reg [31:0] fLim_q [0:1]; // Frequency window
    reg [31:0] dly_q [0:1]; // Settle delay
    reg [`IRQ_W-1:0] irqStat_q; // Sticky events
    reg [`IRQ_W-1:0] irqMask_q; // Enables
    wire [1:0] relW; // Channel outputs
    wire [1:0] evalW;

    // -----------------------------------------------------------------------
    // Two independent instances; second may be blocked by first's eval
    // -----------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            wire crossBlk = (g == 1) && ctrl_q[g][`CTRL_CROSS_BLK] && evalW[0];
            reconnect_channel u_chan (
                .clk(clk),
                .srst(srst),
                .ctrl(ctrl_q[g]),
                .vLim(vLim_q[g]),
                .fLim(fLim_q[g]),
                .settleDelay(dly_q[g]),
                .decoupleIn(decoupleIn),
                .breakerClosed(breakerClosed),
                .voltage(voltage),
                .frequency(frequency),
                .external_voltage_ok_input(external_voltage_ok_input),
                .vt_fuse_failure_input(vt_fuse_failure_input),
                .external_logic_block_input(external_logic_block_input[g]),
                .blockIn(blockIn[g] | crossBlk),
                .reclosePermit(relW[g]),
                .evalActive(evalW[g])
            );
        end
    endgenerate

    // -----------------------------------------------------------------------
    // Outputs straight from flops; events from rising edges
    // -----------------------------------------------------------------------
    wire [`IRQ_W-1:0] events = {evalW & ~evalActive, relW & ~reclosePermit};

    // -----------------------------------------------------------------------
    // Write channel: address and data accepted in either order
    // -----------------------------------------------------------------------
    reg awHave_q; // Address captured
    reg wHave_q; // Data captured
    reg [7:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    wire doWrite = awHave_q && wHave_q && !bvalid;
    wire [`IRQ_W-1:0] w1c = (doWrite && awAddr_q == `REG_IRQ_STAT && wStrb_q[0]) ?
        wData_q[`IRQ_W-1:0] : `IRQ_ZERO;

    // Merge byte lanes of a write
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] st;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (st[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    always @(posedge clk) begin
        if (srst) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= `DATA_ZERO;
            wStrb_q <= 4'h0;
            ctrl_q[0] <= `CTRL_RESET;
            ctrl_q[1] <= `CTRL_RESET;
            vLim_q[0] <= `VLIM_RESET;
            vLim_q[1] <= `VLIM_RESET;
            fLim_q[0] <= `FLIM_RESET;
            fLim_q[1] <= `FLIM_RESET;
            dly_q[0] <= `DLY_RESET;
            dly_q[1] <= `DLY_RESET;
            irqMask_q <= `IRQ_ZERO;
            irqStat_q <= `IRQ_ZERO;
            reclosePermit <= 2'b00;
            evalActive <= 2'b00;
            irq <= 1'b0;
        end else begin
            reclosePermit <= relW;
            evalActive <= evalW;
            // Set wins over a clear in the same cycle
            irqStat_q <= (irqStat_q & ~w1c) | events;
            irq <= |(((irqStat_q & ~w1c) | events) & irqMask_q);
            // One-cycle ready pulses while nothing captured
            awready <= awvalid && !awHave_q && !awready;
            wready <= wvalid && !wHave_q && !wready;
            if (awvalid && awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wHave_q <= 1'b1;
                wData_q <= wdata;
                wStrb_q <= wstrb;
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= `RESP_OKAY;
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                case (awAddr_q)
                    `REG_CTRL0: ctrl_q[0] <= merge(ctrl_q[0], wData_q, wStrb_q);
                    `REG_CTRL1: ctrl_q[1] <= merge(ctrl_q[1], wData_q, wStrb_q);
                    `REG_VLIM0: vLim_q[0] <= merge(vLim_q[0], wData_q, wStrb_q);
                    `REG_FLIM0: fLim_q[0] <= merge(fLim_q[0], wData_q, wStrb_q);
                    `REG_VLIM1: vLim_q[1] <= merge(vLim_q[1], wData_q, wStrb_q);
                    `REG_FLIM1: fLim_q[1] <= merge(fLim_q[1], wData_q, wStrb_q);
                    `REG_DELAY0: dly_q[0] <= merge(dly_q[0], wData_q, wStrb_q);
                    `REG_DELAY1: dly_q[1] <= merge(dly_q[1], wData_q, wStrb_q);
                    `REG_IRQ_MASK: begin
                        if (wStrb_q[0]) begin
                            irqMask_q <= wData_q[`IRQ_W-1:0];
                        end
                    end
                    `REG_IRQ_STAT: begin
                        // Cleared through w1c above
                    end
                    `REG_STAT: begin
                        bresp <= `RESP_DECERR; // Read only
                    end
                    default: bresp <= `RESP_DECERR;
                endcase
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Read channel: answer one cycle after address taken
    // -----------------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= `DATA_ZERO;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= arvalid && !arready && !rvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= `RESP_OKAY;
                case (araddr)
                    `REG_CTRL0: rdata <= ctrl_q[0];
                    `REG_CTRL1: rdata <= ctrl_q[1];
                    `REG_VLIM0: rdata <= vLim_q[0];
                    `REG_FLIM0: rdata <= fLim_q[0];
                    `REG_VLIM1: rdata <= vLim_q[1];
                    `REG_FLIM1: rdata <= fLim_q[1];
                    `REG_DELAY0: rdata <= dly_q[0];
                    `REG_DELAY1: rdata <= dly_q[1];
                    `REG_STAT: rdata <= {28'h000_0000, evalActive, reclosePermit};
                    `REG_IRQ_STAT: rdata <= {28'h000_0000, irqStat_q};
                    `REG_IRQ_MASK: rdata <= {28'h000_0000, irqMask_q};
                    default: begin
                        rdata <= `DATA_ZERO;
                        rresp <= `RESP_DECERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule // reconnect_permit

// ===== dv/reconnect_permit_asserts.sv
// Concurrent checks on the ports of the reconnection permit block
`timescale 1ns/1ps
module reconnect_permit_asserts (
    input wire clk,
    input wire srst,
    input wire awready,
    input wire bvalid,
    input wire bready,
    input wire rvalid,
    input wire rready,
    input wire [1:0] blockIn,
    input wire [1:0] external_logic_block_input,
    input wire [1:0] reclosePermit,
    input wire [1:0] evalActive
);
    // ------------------------------------------------------------------
    // Output relations, all in the single clock domain
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_rel_eval_excl0: assert property (!(reclosePermit[0] && evalActive[0]))
        else $error("release and eval high together on channel 0");
    a_rel_eval_excl1: assert property (!(reclosePermit[1] && evalActive[1]))
        else $error("release and eval high together on channel 1");
    // Release may only follow an evaluation phase
    a_rel_after_eval: assert property ($rose(reclosePermit[0]) |-> $past(evalActive[0]))
        else $error("release rose without evaluation");
    // Evaluation flag falls in the very step the release rises
    a_eval_drop_rel: assert property ($rose(reclosePermit[0]) |-> $fell(evalActive[0]))
        else $error("eval did not drop with release");
    // Two register stages between block input and outputs
    a_block_quiet0: assert property (blockIn[0] [*3] |-> !(reclosePermit[0] || evalActive[0]))
        else $error("channel 0 active while blocked");
    a_block_quiet1: assert property (blockIn[1] [*3] |-> !(reclosePermit[1] || evalActive[1]))
        else $error("channel 1 active while blocked");
    a_extblk_norel: assert property (external_logic_block_input[0] [*3] |-> !reclosePermit[0])
        else $error("release during external logic block");
    a_aw_pulse: assert property (awready |=> !awready)
        else $error("awready longer than one cycle");
    a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("bvalid dropped before bready");
    a_rvalid_hold: assert property (rvalid && !rready |=> rvalid)
        else $error("rvalid dropped before rready");
endmodule // reconnect_permit_asserts

bind reconnect_permit reconnect_permit_asserts chk_i (.clk(clk), .srst(srst),
    .awready(awready), .bvalid(bvalid), .bready(bready), .rvalid(rvalid), .rready(rready),
    .blockIn(blockIn), .external_logic_block_input(external_logic_block_input),
    .reclosePermit(reclosePermit), .evalActive(evalActive));

// ===== dv/field_side_model.sv
// Field-side model: protection trips, breaker feedback and mains supervision
`timescale 1ns/1ps
`include "reconnect_regs.vh"
module field_side_model (
    input wire clk,
    output logic [`DEC_W-1:0] decoupleIn,
    output logic breakerClosed,
    output logic [15:0] voltage,
    output logic [15:0] frequency,
    output logic extOk,
    output logic fuseFail
);
    // ------------------------------------------------------------------
    // Idle grid: breaker closed, nominal frequency in centihertz
    // ------------------------------------------------------------------
    initial begin
        decoupleIn = '0;
        breakerClosed = 1'b1;
        voltage = 16'h1000;
        frequency = 16'h1388;
        extOk = 1'b1;
        fuseFail = 1'b0;
    end
    // Trip first, open while trip stands, drop trip only after the trigger
    task trip_then_open(input int b);
        @(posedge clk);
        decoupleIn[b] <= 1'b1;
        repeat (2) @(posedge clk);
        breakerClosed <= 1'b0;
        repeat (4) @(posedge clk);
        decoupleIn[b] <= 1'b0;
    endtask
    // Short trip pulse, breaker untouched
    task pulse_trip(input int b);
        @(posedge clk);
        decoupleIn[b] <= 1'b1;
        repeat (3) @(posedge clk);
        decoupleIn[b] <= 1'b0;
    endtask
    // Supply side: measured voltage and external release level
    task set_supply(input logic [15:0] v, input logic ok);
        @(posedge clk);
        voltage <= v;
        extOk <= ok;
    endtask
    task set_meas(input logic [15:0] f, input logic fuse, input logic brk);
        @(posedge clk);
        frequency <= f;
        fuseFail <= fuse;
        breakerClosed <= brk;
    endtask
endmodule // field_side_model

// ===== dv/reconnect_permit_tb.sv
// Self-checking testbench of the reconnection permit block
`timescale 1ns/1ps
`include "reconnect_regs.vh"
module reconnect_permit_tb;
    logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_q;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp, extBlk, blockIn, rel, evalActive;
    logic awready, wready, bvalid, arready, rvalid, irq, brk, vok, fuse;
    logic [`DEC_W-1:0] dec;
    logic [15:0] volt, freq;
    int n_errors, cmp_count, cycles, n;
    // Register reset rows: address, data, response
    logic [7:0] rowA [6] = '{`REG_CTRL0, `REG_DELAY0, `REG_VLIM0, `REG_FLIM1, `REG_IRQ_MASK, 8'h30};
    logic [31:0] rowD [6] = '{`CTRL_RESET, `DLY_RESET, `VLIM_RESET, `FLIM_RESET, 32'h0, 32'h0};
    logic [1:0] rowR [6] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b00, `RESP_DECERR};

    reconnect_permit reconnect_permit_i (.clk(clk), .srst(srst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .decoupleIn(dec), .breakerClosed(brk), .voltage(volt),
        .frequency(freq), .external_voltage_ok_input(vok), .vt_fuse_failure_input(fuse),
        .external_logic_block_input(extBlk), .blockIn(blockIn), .reclosePermit(rel),
        .evalActive(evalActive), .irq(irq));
    field_side_model field_side_model_i (.clk(clk), .decoupleIn(dec), .breakerClosed(brk),
        .voltage(volt), .frequency(freq), .extOk(vok), .fuseFail(fuse));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Both channels offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 0;
        w = 0;
        // One edge between calls keeps bready from being set twice in a step
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        forever begin
            @(posedge clk);
            if (!aw && awready) begin aw = 1; awvalid <= 0; end
            if (!w && wready) begin w = 1; wvalid <= 0; end
            if (bvalid) begin resp = bresp; bready <= 0; break; end
        end
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 0;
            if (rvalid) begin rd_q = rdata; resp = rresp; rready <= 0; break; end
        end
    endtask
    // Bounded wait for release, counting evaluation cycles seen
    task wait_rel(input int ch);
        n = 0;
        repeat (300) begin
            @(posedge clk);
            if (rel[ch] === 1'b1) break;
            if (evalActive[ch] === 1'b1) n++;
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin clk = 0; forever #2 clk = ~clk; end
    // Watchdog sized well above the whole sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin n_errors++; report_and_stop; end
    end

    initial begin
        srst = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF; extBlk = 0; blockIn = 0; cycles = 0;
        repeat (6) @(posedge clk);
        srst <= 0;
        chk("outputs after reset", {27'h0, rel, evalActive, irq}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(rowA[i]);
            chk("reset value", rd_q, rowD[i]);
            chk("read resp", resp, rowR[i]);
        end
        wr(`REG_STAT, 32'h0);
        chk("status write resp", resp, `RESP_DECERR);
        $display("test register reset done");
        // Channel 0: decoupling only, frequency window 46.00..54.00
        wr(`REG_FLIM0, 32'h1518_11F8);
        wr(`REG_DELAY0, 32'h3);
        wr(`REG_IRQ_MASK, 32'h1);
        wr(`REG_CTRL0, 32'h0003_FF11);
        field_side_model_i.pulse_trip(5);
        wait_rel(0);
        chk("settle ticks", n >= 4, 1);
        chk("release ch0", rel[0], 1);
        chk("eval drops", evalActive[0], 0);
        chk("irq raised", irq, 1);
        wr(`REG_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq cleared", irq, 0);
        field_side_model_i.set_meas(16'h157C, 0, 1);
        repeat (4) @(posedge clk);
        chk("release lost", rel[0], 0);
        chk("limit trigger", evalActive[0], 1);
        field_side_model_i.set_meas(16'h1388, 0, 1);
        wait_rel(0);
        chk("release again", rel[0], 1);
        field_side_model_i.pulse_trip(9);
        chk("misc source drops", rel[0], 0);
        $display("test decoupling only done");
        // Channel 1: breaker and decoupling assigned
        wr(`REG_CTRL1, 32'h0000_0105);
        field_side_model_i.trip_then_open(0);
        wait_rel(1);
        chk("release ch1", rel[1], 1);
        field_side_model_i.set_meas(16'h1388, 0, 1);
        repeat (4) @(posedge clk);
        chk("close drops", rel[1], 0);
        $display("test breaker mode done");
        // Blocking paths on channel 0
        blockIn <= 2'b01;
        field_side_model_i.pulse_trip(1);
        repeat (6) @(posedge clk);
        chk("blocked eval", evalActive[0], 0);
        blockIn <= 2'b00;
        extBlk <= 2'b01;
        field_side_model_i.pulse_trip(1);
        repeat (30) @(posedge clk);
        chk("logic block", rel[0], 0);
        extBlk <= 2'b00;
        wr(`REG_CTRL0, 32'h0003_FF13);
        field_side_model_i.set_meas(16'h1388, 1, 1);
        field_side_model_i.pulse_trip(1);
        repeat (6) @(posedge clk);
        chk("fuse block", {rel[0], evalActive[0]}, 0);
        $display("test blocking done");
        // Channel 0 with no trigger assignment: byte lanes, voltage window, release input
        field_side_model_i.set_meas(16'h1388, 0, 1);
        wr(`REG_VLIM0, 32'h1100_0F00);
        wstrb <= 4'h6;
        wr(`REG_CTRL0, 32'h0000_0029);
        rd(`REG_CTRL0);
        chk("lanes 1-2 only", rd_q, 32'h0000_0013);
        wstrb <= 4'h1;
        wr(`REG_CTRL0, 32'hFFFF_FF29);
        rd(`REG_CTRL0);
        chk("lane 0 only", rd_q, 32'h0000_0029);
        wstrb <= 4'hF;
        field_side_model_i.set_supply(16'h1000, 0);
        repeat (3) @(posedge clk);
        chk("release input fall", evalActive[0], 1);
        field_side_model_i.set_supply(16'h1000, 1);
        wait_rel(0);
        chk("release no assignment", rel[0], 1);
        field_side_model_i.set_supply(16'h1200, 1);
        repeat (3) @(posedge clk);
        chk("voltage loss", {rel[0], evalActive[0]}, 1);
        $display("test no assignment done");
        // Channel 1 with breaker feedback only
        wr(`REG_CTRL1, 32'h0000_0005);
        field_side_model_i.set_meas(16'h1388, 0, 0);
        wait_rel(1);
        chk("release breaker only", rel[1], 1);
        field_side_model_i.set_meas(16'h1388, 0, 1);
        repeat (4) @(posedge clk);
        chk("breaker close drops", rel[1], 0);
        $display("test breaker only done");
        report_and_stop;
    end
endmodule // reconnect_permit_tb
